// >>> dma_channel_control.sv
// One DMA channel: registers, addressing, progress index and threshold event.
// Assumes a single-word bus master port with a one-cycle acknowledge and a
// peripheral request already routed by the request selector outside.
`timescale 1ns/10ps
`default_nettype none

module dma_channel_control
	import dma_chan_pkg::*;
(
	// Clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    reset_n_i,
	// Register port
	input  wire logic [31:0]             reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [31:0]             reg_rdata_o,
	// Peripheral request and shared interrupt enable
	input  wire logic                    periph_req_i,
	input  wire logic                    irq_enable_i,
	// System bus master
	output logic                         bus_rd_o,
	output logic                         bus_wr_o,
	output logic      [31:0]             bus_addr_o,
	output logic      [1:0]              bus_size_o,
	output logic      [31:0]             bus_wdata_o,
	input  wire logic [31:0]             bus_rdata_i,
	input  wire logic                    bus_ack_i,
	// Status
	output logic                         irq_o,
	output logic                         active_o
);
	import dma_chan_pkg::*;

	// Register targets of the software port.
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_IDX,
		SEL_SRC,
		SEL_DST,
		SEL_THR,
		SEL_LEN,
		SEL_CTRL
	} reg_sel_t;

	// Address decode shared by the write and read paths.
	function automatic reg_sel_t reg_decode(input logic [31:0] addr);
		if (addr == IDX_ADDR) begin
			reg_decode = SEL_IDX;
		end else if (addr == SRC_ADDR) begin
			reg_decode = SEL_SRC;
		end else if (addr == DST_ADDR) begin
			reg_decode = SEL_DST;
		end else if (addr == THR_ADDR) begin
			reg_decode = SEL_THR;
		end else if (addr == LEN_ADDR) begin
			reg_decode = SEL_LEN;
		end else if (addr == CTRL_ADDR) begin
			reg_decode = SEL_CTRL;
		end else begin
			reg_decode = SEL_NONE;
		end
	endfunction

	// Every register of one channel lives here, so further channels are plain copies.
	// Nothing is shared with a neighbour except the bus it competes for and the interrupt enable.
	typedef struct packed {
		chan_phase_t phase;
		logic        en;
		logic [1:0]  width;
		logic        trig;
		logic        dinc;
		logic        sinc;
		logic        circ;
		logic [31:0] src_start;
		logic [31:0] dst_start;
		logic [31:0] cur_src;
		logic [31:0] cur_dst;
		logic [15:0] len;
		logic [15:0] thr;
		logic [15:0] idx;
		logic [31:0] data;
		logic        rd;
		logic        wr;
		logic        irq;
		logic [31:0] rdata;
		logic [31:0] baddr;
		logic        act;
	} chan_state_t;

	// Control register image; bits outside the defined fields read zero.
	function automatic logic [31:0] ctrl_image(input chan_state_t st);
		ctrl_image                       = WORD_ZERO;
		ctrl_image[CTRL_EN_BIT]          = st.en;
		ctrl_image[CTRL_WIDTH_LO +: 2]   = st.width;
		ctrl_image[CTRL_TRIG_BIT]        = st.trig;
		ctrl_image[CTRL_DINC_BIT]        = st.dinc;
		ctrl_image[CTRL_SINC_BIT]        = st.sinc;
		ctrl_image[CTRL_CIRC_BIT]        = st.circ;
	endfunction

	chan_state_t s_r;
	chan_state_t s_nxt;
	logic [31:0] src_step;
	logic [31:0] dst_step;
	logic        last_item;
	logic        wrap;
	logic        item_go;
	logic        thr_hit;
	reg_sel_t    wr_sel;
	reg_sel_t    rd_sel;

	// Address steppers for both sides.
	addr_advance u_src_adv (
		.addr_i  (s_r.cur_src),
		.width_i (s_r.width),
		.inc_i   (s_r.sinc),
		.next_o  (src_step)
	);

	addr_advance u_dst_adv (
		.addr_i  (s_r.cur_dst),
		.width_i (s_r.width),
		.inc_i   (s_r.dinc),
		.next_o  (dst_step)
	);

	assign last_item = (s_r.idx == s_r.len);
	assign wrap      = s_r.circ && s_r.trig;

	// A level request is sampled per item, so a peripheral can pace the channel.
	assign item_go   = !s_r.trig || periph_req_i;
	// The compare uses the index before it steps, one item behind the count.
	assign thr_hit   = (s_r.thr == s_r.idx) && irq_enable_i;

	// Strobes gate the decode so an idle port selects nothing.
	assign wr_sel    = reg_wr_i ? reg_decode(reg_addr_i) : SEL_NONE;
	assign rd_sel    = reg_rd_i ? reg_decode(reg_addr_i) : SEL_NONE;

	always_comb begin
		s_nxt     = s_r;
		s_nxt.irq = 1'b0;

		// Register writes; unmapped addresses are ignored.
		case (wr_sel)
			SEL_CTRL: begin
				s_nxt.width = reg_wdata_i[CTRL_WIDTH_LO +: 2];
				s_nxt.trig  = reg_wdata_i[CTRL_TRIG_BIT];
				s_nxt.dinc  = reg_wdata_i[CTRL_DINC_BIT];
				s_nxt.sinc  = reg_wdata_i[CTRL_SINC_BIT];
				s_nxt.circ  = reg_wdata_i[CTRL_CIRC_BIT];
				// A stopping channel ignores a new enable until idle.
				if (s_r.en || s_r.phase == ST_IDLE) begin
					s_nxt.en = reg_wdata_i[CTRL_EN_BIT];
				end
			end
			SEL_SRC: begin
				s_nxt.src_start = reg_wdata_i;
			end
			SEL_DST: begin
				s_nxt.dst_start = reg_wdata_i;
			end
			SEL_THR: begin
				s_nxt.thr = reg_wdata_i[15:0];
			end
			SEL_LEN: begin
				s_nxt.len = reg_wdata_i[15:0];
			end
			default: begin
				// The index is read-only, so a write to it lands here too.
				s_nxt.len = s_r.len;
			end
		endcase

		// Register reads; unmapped addresses return zero.
		case (rd_sel)
			SEL_CTRL: begin
				s_nxt.rdata = ctrl_image(s_r);
			end
			SEL_IDX: begin
				s_nxt.rdata = {16'h0000, s_r.idx};
			end
			SEL_SRC: begin
				s_nxt.rdata = s_r.src_start;
			end
			SEL_DST: begin
				s_nxt.rdata = s_r.dst_start;
			end
			SEL_THR: begin
				s_nxt.rdata = {16'h0000, s_r.thr};
			end
			SEL_LEN: begin
				s_nxt.rdata = {16'h0000, s_r.len};
			end
			default: begin
				s_nxt.rdata = WORD_ZERO;
			end
		endcase

		case (s_r.phase)
			ST_IDLE: begin
				// Nothing moves while disabled.
				if (s_r.en) begin
					s_nxt.cur_src = s_r.src_start;
					s_nxt.cur_dst = s_r.dst_start;
					s_nxt.idx     = HALF_RESET;
					s_nxt.phase   = ST_ARM;
				end
			end
			ST_ARM: begin
				if (!s_nxt.en) begin
					s_nxt.phase = ST_IDLE;
				end else if (item_go) begin
					s_nxt.rd    = 1'b1;
					s_nxt.phase = ST_READ;
				end
			end
			ST_READ: begin
				if (bus_ack_i) begin
					s_nxt.rd    = 1'b0;
					s_nxt.data  = bus_rdata_i;
					s_nxt.wr    = 1'b1;
					s_nxt.phase = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (bus_ack_i) begin
					s_nxt.wr  = 1'b0;
					s_nxt.irq = thr_hit;
					if (last_item) begin
						if (wrap) begin
							s_nxt.cur_src = s_r.src_start;
							s_nxt.cur_dst = s_r.dst_start;
							s_nxt.idx     = HALF_RESET;
							s_nxt.phase   = s_nxt.en ? ST_ARM : ST_IDLE;
						end else begin
							// Index stays at the programmed length.
							s_nxt.en    = 1'b0;
							s_nxt.phase = ST_IDLE;
						end
					end else begin
						s_nxt.idx     = s_r.idx + 16'h0001;
						s_nxt.cur_src = src_step;
						s_nxt.cur_dst = dst_step;
						// A software disable stops here, after the whole item.
						s_nxt.phase   = s_nxt.en ? ST_ARM : ST_IDLE;
					end
				end
			end
			default: begin
				s_nxt.phase = ST_IDLE;
			end
		endcase

		// Bus address and busy flag are registered, so no output leaves through gates.
		// The address follows the phase being entered, keeping it stable for the whole access.
		if (s_nxt.phase == ST_WRITE) begin
			s_nxt.baddr = s_nxt.cur_dst;
		end else begin
			s_nxt.baddr = s_nxt.cur_src;
		end
		s_nxt.act = (s_nxt.phase != ST_IDLE);
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r.phase     <= ST_IDLE;
			s_r.en        <= 1'b0;
			s_r.width     <= WIDTH_BYTE;
			s_r.trig      <= 1'b0;
			s_r.dinc      <= 1'b0;
			s_r.sinc      <= 1'b0;
			s_r.circ      <= 1'b0;
			s_r.src_start <= ADDR_RESET;
			s_r.dst_start <= ADDR_RESET;
			s_r.cur_src   <= ADDR_RESET;
			s_r.cur_dst   <= ADDR_RESET;
			s_r.len       <= HALF_RESET;
			s_r.thr       <= HALF_RESET;
			s_r.idx       <= HALF_RESET;
			s_r.data      <= WORD_ZERO;
			s_r.rd        <= 1'b0;
			s_r.wr        <= 1'b0;
			s_r.irq       <= 1'b0;
			s_r.rdata     <= WORD_ZERO;
			s_r.baddr     <= ADDR_RESET;
			s_r.act       <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Every output below is a field of the registered state.
	assign reg_rdata_o = s_r.rdata;
	assign bus_rd_o    = s_r.rd;
	assign bus_wr_o    = s_r.wr;
	assign bus_addr_o  = s_r.baddr;
	assign bus_size_o  = s_r.width;
	assign bus_wdata_o = s_r.data;
	assign irq_o       = s_r.irq;
	assign active_o    = s_r.act;
endmodule
`default_nettype wire

// >>> dma_chan_pkg.sv
// Constants and types shared by the DMA channel control block.
// Assumes a 32-bit byte-addressed register space and a 32-bit system bus.
package dma_chan_pkg;

	// Register byte addresses.
	localparam logic [31:0] IDX_ADDR   = 32'h5006_0234;
	localparam logic [31:0] SRC_ADDR   = 32'h5006_0240;
	localparam logic [31:0] DST_ADDR   = 32'h5006_0244;
	localparam logic [31:0] THR_ADDR   = 32'h5006_0248;
	localparam logic [31:0] LEN_ADDR   = 32'h5006_024C;
	localparam logic [31:0] CTRL_ADDR  = 32'h5006_0250;

	// Field positions of the channel_control register.
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_WIDTH_LO  = 1;
	localparam int CTRL_TRIG_BIT  = 3;
	localparam int CTRL_DINC_BIT  = 4;
	localparam int CTRL_SINC_BIT  = 5;
	localparam int CTRL_CIRC_BIT  = 6;

	// Reset values.
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [15:0] HALF_RESET = 16'h0000;
	localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

	// Transfer width codes.
	localparam logic [1:0] WIDTH_BYTE = 2'h0;
	localparam logic [1:0] WIDTH_HALF = 2'h1;
	localparam logic [1:0] WIDTH_WORD = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARM,
		ST_READ,
		ST_WRITE
	} chan_phase_t;

	// Byte step of one item for a width code; the reserved code moves nothing.
	function automatic logic [31:0] width_step(input logic [1:0] code);
		if (code == WIDTH_BYTE) begin
			width_step = 32'h0000_0001;
		end else if (code == WIDTH_HALF) begin
			width_step = 32'h0000_0002;
		end else if (code == WIDTH_WORD) begin
			width_step = 32'h0000_0004;
		end else begin
			width_step = 32'h0000_0000;
		end
	endfunction

endpackage

// >>> addr_advance.sv
// Next-address calculator for one side of a DMA channel.
// Assumes the width code is stable while the result is used.
`timescale 1ns/10ps
`default_nettype none
module addr_advance
	import dma_chan_pkg::*;
(
	// Current address and controls
	input  wire logic [31:0] addr_i,
	input  wire logic [1:0]  width_i,
	input  wire logic        inc_i,
	// Result
	output logic      [31:0] next_o
);
	always_comb begin
		if (inc_i) begin
			next_o = addr_i + width_step(width_i);
		end else begin
			next_o = addr_i;
		end
	end
endmodule
`default_nettype wire

// >>> dma_channel_control_properties.sv
// Timing checks on the bus, register and event ports of one DMA channel.
// Assumes it is bound to dma_channel_control and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_control_properties (
	// Watched ports
	input wire logic        sys_clk_i,
	input wire logic        reset_n_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        irq_enable_i,
	input wire logic        bus_rd_o,
	input wire logic        bus_wr_o,
	input wire logic [31:0] bus_addr_o,
	input wire logic        bus_ack_i,
	input wire logic        irq_o,
	input wire logic        active_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_rd_hold; bus_rd_o && !bus_ack_i |=> bus_rd_o && $stable(bus_addr_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read request dropped early");
	property p_wr_hold; bus_wr_o && !bus_ack_i |=> bus_wr_o && $stable(bus_addr_o); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write request dropped early");
	property p_rd_to_wr; bus_rd_o && bus_ack_i |=> bus_wr_o && !bus_rd_o; endproperty
	a_rd_to_wr: assert property (p_rd_to_wr) else $error("read not followed by write");
	property p_wr_gap; bus_wr_o && bus_ack_i |=> !bus_rd_o && !bus_wr_o; endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("no gap after item write");
	property p_one_op; !(bus_rd_o && bus_wr_o); endproperty
	a_one_op: assert property (p_one_op) else $error("read and write together");
	property p_idle_quiet; !active_o |-> !bus_rd_o && !bus_wr_o; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("bus used while idle");
	property p_irq_cause; irq_o |-> $past(bus_wr_o && bus_ack_i && irq_enable_i); endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("event without cause");
	property p_irq_pulse; irq_o |=> !irq_o; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("event longer than a cycle");
	property p_rdata_zero; !reg_rd_i |=> reg_rdata_o == 32'h0000_0000; endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("read data without read");
endmodule
bind dma_channel_control dma_channel_control_properties u_props (.sys_clk_i, .reset_n_i,
	.reg_rd_i, .reg_rdata_o, .irq_enable_i, .bus_rd_o, .bus_wr_o, .bus_addr_o, .bus_ack_i,
	.irq_o, .active_o);
`default_nettype wire

// >>> bus_memory_model.sv
// Memory on the system bus side of one DMA channel, with a settable answer delay.
// Assumes one request at a time, held until acknowledged.
`timescale 1ns/10ps
`default_nettype none
module bus_memory_model (
	// Clock, reset and delay
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  wait_i,
	// Bus from the channel
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic      [31:0] rdata_o,
	output logic             ack_o,
	// Log of the last item and a count of written items
	output logic      [31:0] raddr_o,
	output logic      [31:0] waddr_o,
	output logic      [31:0] wlog_o,
	output logic      [15:0] items_o
);
	logic [3:0] cnt_r;
	logic       answer;
	assign answer = (rd_i || wr_i) && !ack_o && cnt_r >= wait_i;
	// Data lines never hold a stale word between answers, so a late sample is caught.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 4'h0;
			ack_o <= 1'b0;
			rdata_o <= 32'h0000_0000;
			items_o <= 16'h0000;
		end else begin
			ack_o <= answer;
			rdata_o <= ~rdata_o;
			cnt_r <= ((rd_i || wr_i) && !ack_o && !answer) ? cnt_r + 4'h1 : 4'h0;
			if (answer && rd_i) begin
				rdata_o <= addr_i ^ 32'h5A5A_5A5A;
				raddr_o <= addr_i;
			end
			if (answer && wr_i) begin
				waddr_o <= addr_i;
				wlog_o <= wdata_i;
				items_o <= items_o + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dma_channel_control_bench.sv
// Self-checking bench for one DMA channel: register access, transfers, modes.
// Assumes the bus memory model and the bound property checker.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_control_bench;
	import dma_chan_pkg::*;
	logic        clk, rst_n, reg_wr, reg_rd, periph_req, irq_en, bus_rd, bus_wr, bus_ack;
	logic        irq, active;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, bus_addr, bus_wdata, bus_rdata;
	logic [31:0] raddr, waddr, wlog, d, step, src, dst;
	logic [1:0]  bus_size, w;
	logic [3:0]  mwait;
	logic [15:0] items, base;
	int          checked, miscompares, irqs, cyc;
	dma_channel_control u_dut (.sys_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.periph_req_i(periph_req), .irq_enable_i(irq_en), .bus_rd_o(bus_rd), .bus_wr_o(bus_wr),
		.bus_addr_o(bus_addr), .bus_size_o(bus_size), .bus_wdata_o(bus_wdata),
		.bus_rdata_i(bus_rdata), .bus_ack_i(bus_ack), .irq_o(irq), .active_o(active));
	bus_memory_model u_mem (.clk_i(clk), .rst_n_i(rst_n), .wait_i(mwait), .rd_i(bus_rd),
		.wr_i(bus_wr), .addr_i(bus_addr), .wdata_i(bus_wdata), .rdata_o(bus_rdata),
		.ack_o(bus_ack), .raddr_o(raddr), .waddr_o(waddr), .wlog_o(wlog), .items_o(items));
	task automatic tally_and_finish;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// One idle edge keeps back-to-back writes from driving the strobe twice at once.
		@(posedge clk);
	endtask
	task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
		if (n != "") check(n, d, e);
	endtask
	// Software must see enable low before it may set it again.
	task automatic wait_off;
		d = 32'h1;
		for (int k = 0; k < 300 && d[0] !== 1'b0; k++) rc("", CTRL_ADDR, 0);
		check("en off", {31'h0, d[0]}, 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (irq === 1'b1) irqs++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_n, reg_wr, reg_rd, periph_req, irq_en, mwait} = '0;
		{reg_addr, reg_wdata} = '0;
		src = 32'h1000_0100;
		dst = 32'h2000_0200;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc("idx", IDX_ADDR, 32'h0000_0000);
		rc("src", SRC_ADDR, 32'h0000_0000);
		rc("dst", DST_ADDR, 32'h0000_0000);
		rc("thr", THR_ADDR, 32'h0000_0000);
		rc("hole", 32'h5006_0238, 32'h0000_0000);
		wr(IDX_ADDR, 32'hFFFF_FFFF);
		rc("idx ro", IDX_ADDR, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			w = (i == 3) ? WIDTH_WORD : i[1:0];
			step = (i == 3) ? 32'h0 : (32'h1 << w);
			mwait <= {2'b00, i[1:0]};
			irq_en <= (i != 3);
			base = items;
			wr(SRC_ADDR, src);
			wr(DST_ADDR, dst);
			rc("src", SRC_ADDR, src);
			rc("dst", DST_ADDR, dst);
			wr(LEN_ADDR, 32'h0000_0002);
			wr(THR_ADDR, 32'h0000_0001);
			irqs = 0;
			wr(CTRL_ADDR, 32'h1 | {29'h0, w, 1'b0} | ((i == 3) ? 32'h0 : 32'h30));
			wait_off();
			rc("idx", IDX_ADDR, 32'h0000_0002);
			check("items", {16'h0, items - base}, 32'h3);
			check("rd addr", raddr, src + 2 * step);
			check("wr addr", waddr, dst + 2 * step);
			check("data", wlog, (src + 2 * step) ^ 32'h5A5A_5A5A);
			check("size", {30'h0, bus_size}, {30'h0, w});
			check("irq", irqs, (i != 3));
		end
		base = items;
		wr(LEN_ADDR, 32'h0000_0000);
		wr(CTRL_ADDR, 32'h0000_0009);
		repeat (30) @(posedge clk);
		check("held", {16'h0, items}, {16'h0, base});
		periph_req <= 1'b1;
		wait_off();
		check("one", {16'h0, items - base}, 32'h1);
		rc("idx new", IDX_ADDR, 32'h0000_0000);
		base = items;
		wr(LEN_ADDR, 32'h0000_0001);
		wr(CTRL_ADDR, 32'h0000_0049);
		repeat (100) @(posedge clk);
		rc("circ", CTRL_ADDR, 32'h0000_0049);
		check("wraps", {31'h0, items > base + 16'd3}, 32'h1);
		while (bus_rd !== 1'b1) @(posedge clk);
		wr(CTRL_ADDR, 32'h0000_0048);
		wr(CTRL_ADDR, 32'h0000_0049);
		wait_off();
		// Enable reads zero at once; the item in flight still needs time to finish.
		repeat (20) @(posedge clk);
		check("stop", {31'h0, active}, 32'h0);
		rc("", IDX_ADDR, 0);
		check("idx wrap", {31'h0, d < 32'h2}, 32'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
